// File: core/csr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module csr_regs (
    // system clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // bus link
    input  wire logic       smbClk,
    input  wire logic       sdaIn,
    output var  logic       sdaOut,
    output var  logic       sdaOe,
    // strap
    input  wire logic       base_speed_strap,
    // control outputs
    output var  logic [7:0] diffOutputEnables,
    output var  logic [3:0] cpuOutputEnables,
    output var  logic       crystal_ref_out_en,
    output var  logic [5:0] singleEndedEnables,
    output var  logic       spreadEnable,
    output var  logic [4:0] fixedClockSelect,
    output var  logic [3:0] mainFreqSelect,
    output var  logic       testEntry,
    output var  logic       testOutputType,
    output var  logic       baseSpeed100
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] diffEn_q;
    logic [7:0] cpuRef_q;
    logic [7:0] seEn_q;
    logic [4:0] margin_q;
    logic [7:0] testFreq_q;
    logic [7:0] byteCount_q;
    logic       strap_q;
    logic       strapSync;
    logic       strapDone_q;

    // link-domain signals
    logic [7:0] linkIdx;
    logic [7:0] linkWrData;
    logic       linkWrToggle;
    logic       linkSdaOe;
    logic [7:0] linkRdData_q;
    logic       linkReset;

    // system-domain copies; readMeta_q is the first smbClk stage of the read path
    logic       wrTogSync;
    logic       wrTogSeen_q;
    logic [7:0] wrIdx_q;
    logic [7:0] wrDat_q;
    logic [7:0] wrIdxMeta_q;
    logic [7:0] wrDatMeta_q;
    logic [7:0] linkIdxMeta_q;
    logic [7:0] linkIdxSync_q;
    logic [7:0] readBack_q;
    logic [7:0] readMeta_q;
    logic       oeMeta_q;

    function automatic logic [7:0] csrReadMux(input logic [7:0] idx);
        case (idx)
            csr_pkg::IDX_DIFF_EN:    csrReadMux = diffEn_q;
            csr_pkg::IDX_CPU_REF:    csrReadMux = cpuRef_q;
            csr_pkg::IDX_SE_EN:      csrReadMux = seEn_q;
            csr_pkg::IDX_MARGIN:     csrReadMux = {3'h0, margin_q};
            csr_pkg::IDX_TEST_FREQ:  csrReadMux = testFreq_q;
            csr_pkg::IDX_VEND_REV:   csrReadMux = {csr_pkg::REVISION_VALUE, csr_pkg::MAKER_VALUE};
            csr_pkg::IDX_BYTE_COUNT: csrReadMux = byteCount_q;
            csr_pkg::IDX_DEV_ID:     csrReadMux = csr_pkg::PART_VALUE;
            default:                 csrReadMux = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // link side
    csr_sync2 u_resetSync (
        .clk  (smbClk),
        .din  (reset),
        .dout (linkReset)
    );

    csr_smb_slave u_slave (
        .smbClk    (smbClk),
        .busReset  (linkReset),
        .sdaIn     (sdaIn),
        .sdaOe     (linkSdaOe),
        .regIdx    (linkIdx),
        .wrData    (linkWrData),
        .wrToggle  (linkWrToggle),
        .rdData    (linkRdData_q),
        .byteCount (byteCount_q)
    );

    // read data is quasi-static: registers only change on bus writes, apart from the strap bit of byte 6 caught after reset
    always_ff @(posedge smbClk) begin
        readMeta_q   <= readBack_q;
        linkRdData_q <= readMeta_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // crossings into ref_clk
    csr_sync2 u_wrSync (
        .clk  (ref_clk),
        .din  (linkWrToggle),
        .dout (wrTogSync)
    );

    // index stable at least seven bit times before the toggle moves; data changes on the same edge as the toggle
    always_ff @(posedge ref_clk) begin
        wrIdxMeta_q   <= linkIdx;
        wrDatMeta_q   <= linkWrData;
        wrIdx_q       <= wrIdxMeta_q;
        wrDat_q       <= wrDatMeta_q;
        linkIdxMeta_q <= linkIdx;
        linkIdxSync_q <= linkIdxMeta_q;
        oeMeta_q      <= linkSdaOe;
        sdaOe         <= oeMeta_q;
        sdaOut        <= 1'b0;
    end

    logic wrPulse;
    logic wrPulse_q;
    assign wrPulse = wrTogSync != wrTogSeen_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wrTogSeen_q <= 1'b0;
            wrPulse_q   <= 1'b0;
            readBack_q  <= 8'h00;
        end else begin
            wrTogSeen_q <= wrTogSync;
            // held back a cycle so a data flop that went metastable has settled
            wrPulse_q   <= wrPulse;
            readBack_q  <= csrReadMux(linkIdxSync_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap caught once after reset release
    csr_sync2 u_strapSync (
        .clk  (ref_clk),
        .din  (base_speed_strap),
        .dout (strapSync)
    );

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            strapDone_q <= 1'b0;
            strap_q     <= 1'b1;
        end else if (!strapDone_q) begin
            strapDone_q <= 1'b1;
            strap_q     <= strapSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes; framing handled by the slave
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            diffEn_q    <= csr_pkg::RST_DIFF_EN;
            cpuRef_q    <= csr_pkg::RST_CPU_REF;
            seEn_q      <= csr_pkg::RST_SE_EN;
            margin_q    <= csr_pkg::RST_MARGIN;
            testFreq_q  <= {4'h0, csr_pkg::RST_FREQ_SEL};
            byteCount_q <= csr_pkg::RST_BYTE_COUNT;
        end else begin
            if (wrPulse_q) begin
                case (wrIdx_q)
                    csr_pkg::IDX_DIFF_EN:    diffEn_q <= wrDat_q;
                    csr_pkg::IDX_CPU_REF:    cpuRef_q <= wrDat_q & csr_pkg::WMASK_CPU_REF;
                    csr_pkg::IDX_SE_EN:      seEn_q <= wrDat_q & csr_pkg::WMASK_SE_EN;
                    csr_pkg::IDX_MARGIN:     margin_q <= wrDat_q[4:0];
                    csr_pkg::IDX_TEST_FREQ: begin
                        testFreq_q[csr_pkg::TEST_TYPE_BIT]  <= wrDat_q[csr_pkg::TEST_TYPE_BIT];
                        testFreq_q[csr_pkg::TEST_ENTRY_BIT] <= wrDat_q[csr_pkg::TEST_ENTRY_BIT];
                        testFreq_q[3:0]                     <= wrDat_q[3:0];
                    end
                    csr_pkg::IDX_BYTE_COUNT: byteCount_q <= wrDat_q;
                    default: ;
                endcase
            end
            testFreq_q[csr_pkg::STRAP_BIT] <= strap_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        diffOutputEnables  <= diffEn_q;
        cpuOutputEnables   <= cpuRef_q[4:1];
        crystal_ref_out_en <= cpuRef_q[7];
        singleEndedEnables <= seEn_q[5:0];
        spreadEnable       <= cpuRef_q[csr_pkg::SPREAD_BIT];
        fixedClockSelect   <= margin_q;
        mainFreqSelect     <= testFreq_q[3:0];
        testEntry          <= testFreq_q[csr_pkg::TEST_ENTRY_BIT];
        testOutputType     <= testFreq_q[csr_pkg::TEST_TYPE_BIT];
        baseSpeed100       <= strap_q;
    end
endmodule
`default_nettype wire

// File: core/csr_smb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module csr_smb_slave (
    // bus clock and reset
    input  wire logic       smbClk,
    input  wire logic       busReset,
    // data pin
    input  wire logic       sdaIn,
    output var  logic       sdaOe,
    // register side
    output var  logic [7:0] regIdx,
    output var  logic [7:0] wrData,
    output var  logic       wrToggle,
    input  wire logic [7:0] rdData,
    input  wire logic [7:0] byteCount
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_INDEX = 3'b010,
        ST_COUNT = 3'b011,
        ST_WDATA = 3'b100,
        ST_RCNT  = 3'b101,
        ST_RDATA = 3'b110,
        ST_DONE  = 3'b111
    } csr_smb_st_t;

    csr_smb_st_t state_q;
    logic [7:0]  shift_q;
    logic [3:0]  bit_q;
    logic        ackPhase_q;
    logic        startSeen_q;
    logic        stopSeen_q;
    logic        sdaPos_q;
    logic        dataSeen_q;
    logic [7:0]  txByte_q;
    logic        readMode;
    logic [7:0]  rxByte;

    assign rxByte   = {shift_q[6:0], sdaIn};
    assign readMode = (state_q == ST_RCNT) || (state_q == ST_RDATA);

    // start/stop: sda moved while scl stayed high, so the level at the falling
    // edge differs from the one at the rising edge; data bits only move with scl low
    // limitation: a stop is only acted on once scl falls and rises again
    always_ff @(posedge smbClk) begin
        sdaPos_q <= sdaIn;
    end
    always_ff @(negedge smbClk) begin
        startSeen_q <= sdaPos_q && !sdaIn;
        stopSeen_q  <= !sdaPos_q && sdaIn;
    end

    always_ff @(posedge smbClk) begin
        if (busReset) begin
            state_q    <= ST_IDLE;
            bit_q      <= 4'h0;
            ackPhase_q <= 1'b0;
            shift_q    <= 8'h00;
            wrToggle   <= 1'b0;
            regIdx     <= 8'h00;
            wrData     <= 8'h00;
            txByte_q   <= 8'h00;
            dataSeen_q <= 1'b0;
        end else if (stopSeen_q) begin
            // toggle, index and data kept: clearing them would fake a write
            state_q    <= ST_IDLE;
            bit_q      <= 4'h0;
            ackPhase_q <= 1'b0;
        end else if (startSeen_q) begin
            state_q    <= ST_ADDR;
            bit_q      <= 4'h1;
            ackPhase_q <= 1'b0;
            dataSeen_q <= 1'b0;
            shift_q    <= {7'h00, sdaIn};
        end else if (ackPhase_q) begin
            ackPhase_q <= 1'b0;
            bit_q      <= 4'h0;
            if (readMode && sdaIn) begin
                state_q <= ST_DONE; // host nack ends the read
            end
        end else if (bit_q == 4'h7) begin
            ackPhase_q <= 1'b1;
            bit_q      <= 4'h0;
            shift_q    <= rxByte;
            case (state_q)
                ST_ADDR: begin
                    if (rxByte[7:1] != csr_pkg::BUS_ADDR7) begin
                        state_q    <= ST_DONE;
                        ackPhase_q <= 1'b0;
                    end else if (rxByte[0]) begin
                        state_q  <= ST_RCNT;
                        txByte_q <= byteCount;
                    end else begin
                        state_q <= ST_INDEX;
                    end
                end
                ST_INDEX: begin
                    regIdx  <= rxByte;
                    state_q <= ST_COUNT;
                end
                ST_COUNT: state_q <= ST_WDATA;
                ST_WDATA: begin
                    wrData     <= rxByte;
                    wrToggle   <= !wrToggle;
                    dataSeen_q <= 1'b1;
                end
                // index steps as each byte is loaded, so the next word has
                // nine bit times to come back through the crossing
                ST_RCNT: begin
                    state_q  <= ST_RDATA;
                    regIdx   <= regIdx + 8'h01;
                    txByte_q <= rdData;
                end
                ST_RDATA: begin
                    regIdx   <= regIdx + 8'h01;
                    txByte_q <= rdData;
                end
                default: begin
                    state_q    <= ST_DONE;
                    ackPhase_q <= 1'b0;
                end
            endcase
        end else begin
            bit_q   <= bit_q + 4'h1;
            shift_q <= rxByte;
            if (state_q == ST_WDATA && bit_q == 4'h0 && dataSeen_q) begin
                regIdx <= regIdx + 8'h01;
            end
        end
    end

    // sda driven on falling scl so it is stable at the rising edge
    always_ff @(negedge smbClk) begin
        if (busReset) begin
            sdaOe <= 1'b0;
        end else if (ackPhase_q) begin
            sdaOe <= !readMode || state_q == ST_RCNT;
        end else if (readMode) begin
            sdaOe <= !txByte_q[3'(7 - bit_q)];
        end else begin
            sdaOe <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: core/csr_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module csr_sync2 (
    // clock
    input  wire logic clk,
    // level in and out
    input  wire logic din,
    output var  logic dout
);
    logic meta_q;

    always_ff @(posedge clk) begin
        meta_q <= din;
        dout   <= meta_q;
    end
endmodule
`default_nettype wire

// File: include/csr_pkg.sv
package csr_pkg;
    // register indices
    localparam logic [7:0] IDX_DIFF_EN    = 8'h00;
    localparam logic [7:0] IDX_CPU_REF    = 8'h01;
    localparam logic [7:0] IDX_SE_EN      = 8'h02;
    localparam logic [7:0] IDX_RSVD3      = 8'h03;
    localparam logic [7:0] IDX_RSVD4      = 8'h04;
    localparam logic [7:0] IDX_MARGIN     = 8'h05;
    localparam logic [7:0] IDX_TEST_FREQ  = 8'h06;
    localparam logic [7:0] IDX_VEND_REV   = 8'h07;
    localparam logic [7:0] IDX_BYTE_COUNT = 8'h08;
    localparam logic [7:0] IDX_DEV_ID     = 8'h09;
    localparam int         NUM_REGS       = 10;

    // reset values
    localparam logic [7:0] RST_DIFF_EN    = 8'hFF;
    localparam logic [7:0] RST_CPU_REF    = 8'h9E;
    localparam logic [7:0] RST_SE_EN      = 8'h3F;
    localparam logic [4:0] RST_MARGIN     = 5'h0F;
    localparam logic [3:0] RST_FREQ_SEL   = 4'h8;
    localparam logic [7:0] RST_BYTE_COUNT = 8'h0A;

    // writable masks
    localparam logic [7:0] WMASK_CPU_REF  = 8'h9F;
    localparam logic [7:0] WMASK_SE_EN    = 8'h3F;

    // byte 6 field positions, plus the spread bit of byte 1
    localparam int TEST_TYPE_BIT  = 7;
    localparam int TEST_ENTRY_BIT = 6;
    localparam int STRAP_BIT      = 4;
    localparam int SPREAD_BIT     = 0;

    // smbus address (7-bit form, direction bit appended as lsb on the wire)
    localparam logic [6:0] BUS_ADDR7 = 7'h69;

    // identity values, arbitrary
    localparam logic [3:0] REVISION_VALUE = 4'h5;
    localparam logic [3:0] MAKER_VALUE    = 4'hA;
    localparam logic [7:0] PART_VALUE     = 8'h5C;
endpackage

// File: tb/csr_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module csr_props_checker (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    // link and strap
    input wire logic       smbClk,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       base_speed_strap,
    // fields
    input wire logic [7:0] diffOutputEnables,
    input wire logic [3:0] cpuOutputEnables,
    input wire logic       crystal_ref_out_en,
    input wire logic [5:0] singleEndedEnables,
    input wire logic       spreadEnable,
    input wire logic [4:0] fixedClockSelect,
    input wire logic [3:0] mainFreqSelect,
    input wire logic       testEntry,
    input wire logic       testOutputType,
    input wire logic       baseSpeed100
);
    logic       sclQ;
    logic [5:0] idleQ;
    logic [3:0] sinceQ;
    ////////////////////////////////////////////////////////////////
    // bus quiet time in ref_clk cycles
    always_ff @(posedge ref_clk) begin
        sclQ <= smbClk;
        if (reset || smbClk != sclQ) idleQ <= 6'h00;
        else if (idleQ != 6'h3F) idleQ <= idleQ + 6'h01;
    end
    // strap capture gets some slack after release
    always_ff @(posedge ref_clk) begin
        if (reset) sinceQ <= 4'h0;
        else if (sinceQ != 4'hF) sinceQ <= sinceQ + 4'h1;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_rel;
        $fell(reset);
    endsequence
    sequence s_quiet;
        idleQ > 6'h1E;
    endsequence
    a_diff_rst_val: assert property (s_rel |-> diffOutputEnables == 8'hFF)
        else $error("diff enables wrong after reset");
    a_enable_rst_val: assert property (s_rel |-> {cpuOutputEnables, crystal_ref_out_en, singleEndedEnables} == 11'h7FF)
        else $error("enables wrong after reset");
    a_spread_rst_off: assert property (s_rel |-> !spreadEnable ##1 !spreadEnable)
        else $error("spread on after reset");
    a_main_rst_val: assert property (s_rel |-> mainFreqSelect == csr_pkg::RST_FREQ_SEL)
        else $error("main select wrong after reset");
    a_test_rst_off: assert property (s_rel |-> !testEntry && !testOutputType)
        else $error("test bits set after reset");
    a_strap_held: assert property (sinceQ == 4'hF |-> baseSpeed100 == base_speed_strap && $stable(baseSpeed100))
        else $error("base speed not the latched strap");
    a_fixed_rst_val: assert property (s_rel |-> fixedClockSelect == 5'h0F)
        else $error("fixed select wrong after reset");
    a_fields_quiet: assert property (s_quiet |-> $stable({diffOutputEnables, cpuOutputEnables, spreadEnable,
        fixedClockSelect, mainFreqSelect, testEntry, testOutputType}))
        else $error("field changed with bus idle");
    a_idle_release: assert property (s_quiet and smbClk |-> !sdaOe)
        else $error("data line pulled while idle");
    a_pull_only: assert property (sdaOe |-> !sdaOut)
        else $error("data line driven high");
endmodule
bind csr_regs csr_props_checker u_props (.ref_clk(ref_clk), .reset(reset), .smbClk(smbClk), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .base_speed_strap(base_speed_strap), .diffOutputEnables(diffOutputEnables),
    .cpuOutputEnables(cpuOutputEnables), .crystal_ref_out_en(crystal_ref_out_en),
    .singleEndedEnables(singleEndedEnables), .spreadEnable(spreadEnable), .fixedClockSelect(fixedClockSelect),
    .mainFreqSelect(mainFreqSelect), .testEntry(testEntry), .testOutputType(testOutputType),
    .baseSpeed100(baseSpeed100));
`default_nettype wire

// File: tb/csr_smb_host.sv
`timescale 1ns/1ps
`default_nettype none
module csr_smb_host (
    // link wires
    output var  logic scl,
    output wire logic sda,
    input  wire logic devPull
);
    localparam time Q = 260;
    logic       hostLow;
    logic       ackAll;
    logic [7:0] cnt;
    logic [7:0] wrBuf [10];
    logic [7:0] rdBuf [10];
    // pulled-up line, so a release never shows a stale level
    assign sda = ~(hostLow | devPull);
    initial begin
        scl = 1'h1;
        hostLow = 1'h0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic bit_cyc(input logic b, output logic s);
        scl = 1'h0;
        #Q hostLow = !b;
        #Q scl = 1'h1;
        s = sda;
        #(2*Q);
    endtask
    // link reset needs edges of its own
    task automatic pulses();
        repeat (4) begin
            #32 scl = 1'h0;
            #32 scl = 1'h1;
        end
    endtask
    task automatic start();
        hostLow = 1'h1;
        #(2*Q);
    endtask
    task automatic stop();
        scl = 1'h0;
        #Q hostLow = 1'h1;
        #Q scl = 1'h1;
        #Q hostLow = 1'h0;
        #Q scl = 1'h0;
        #(2*Q) scl = 1'h1;
        #(2*Q);
    endtask
    task automatic send(input logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cyc(v[i], s);
        bit_cyc(1'h1, s);
        ackAll &= !s;
    endtask
    task automatic recv(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cyc(1'h1, v[i]);
        bit_cyc(last, s);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic write_block(input logic [7:0] idx, input int n);
        ackAll = 1'h1;
        start();
        send({csr_pkg::BUS_ADDR7, 1'h0});
        send(idx);
        send(8'(n));
        for (int i = 0; i < n; i++) send(wrBuf[i]);
        stop();
    endtask
    task automatic read_block(input logic [7:0] idx, input int n);
        logic s;
        ackAll = 1'h1;
        start();
        send({csr_pkg::BUS_ADDR7, 1'h0});
        send(idx);
        bit_cyc(1'h1, s);
        start();
        send({csr_pkg::BUS_ADDR7, 1'h1});
        recv(1'h0, cnt);
        for (int i = 0; i < n; i++) recv(i == n - 1, rdBuf[i]);
        stop();
    endtask
    task automatic probe(input logic [7:0] a);
        ackAll = 1'h1;
        start();
        send(a);
        stop();
    endtask
endmodule
`default_nettype wire

// File: tb/test_clock_synth_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("Error %0t: got %h want %h", $time, (g), (e)); end end
module test_clock_synth_control_regs;
    localparam logic [7:0] ID = {csr_pkg::REVISION_VALUE, csr_pkg::MAKER_VALUE};
    localparam logic [7:0] PT = csr_pkg::PART_VALUE;
    logic        ref_clk;
    logic        reset;
    logic        strap;
    wire         smbClk;
    wire         sdaIn;
    wire         sdaOe;
    wire  [31:0] fields;
    int          n_errors;
    int          compares;
    csr_smb_host host (.scl(smbClk), .sda(sdaIn), .devPull(sdaOe));
    csr_regs dut (.ref_clk(ref_clk), .reset(reset), .smbClk(smbClk), .sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe),
        .base_speed_strap(strap), .diffOutputEnables(fields[31:24]), .cpuOutputEnables(fields[23:20]),
        .crystal_ref_out_en(fields[19]), .singleEndedEnables(fields[18:13]), .spreadEnable(fields[12]),
        .fixedClockSelect(fields[11:7]), .mainFreqSelect(fields[6:3]), .testEntry(fields[2]),
        .testOutputType(fields[1]), .baseSpeed100(fields[0]));
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    // hang guard, well past the expected run length
    initial begin
        #3900000;
        n_errors++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        @(negedge ref_clk);
        strap = s;
        reset = 1'h1;
        host.pulses();
        repeat (2) @(negedge ref_clk);
        reset = 1'h0;
        // link reset is synchronised, so it needs scl edges after release too
        host.pulses();
        repeat (20) @(negedge ref_clk);
    endtask
    task automatic check_image(input logic [79:0] e);
        host.read_block(8'h00, 10);
        `CHK(host.ackAll, 1'h1)
        `CHK(host.cnt, e[71:64])
        for (int i = 0; i < 10; i++) `CHK(host.rdBuf[i], e[8*i +: 8])
    endtask
    task automatic fill(input logic [7:0] v);
        for (int i = 0; i < 10; i++) host.wrBuf[i] = v;
        host.write_block(8'h00, 10);
        `CHK(host.ackAll, 1'h1)
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'h1;
        strap = 1'h1;
        n_errors = 0;
        compares = 0;
        do_reset(1'h1);
        `CHK(fields, {8'hFF, 4'hF, 1'h1, 6'h3F, 1'h0, 5'h0F, 4'h8, 1'h0, 1'h0, 1'h1})
        check_image({PT, 8'h0A, ID, 8'h18, 8'h0F, 16'h0, 8'h3F, 8'h9E, 8'hFF});
        fill(8'h00);
        `CHK(fields, 32'h0000_0001)
        check_image({PT, 8'h00, ID, 8'h10, 48'h0});
        fill(8'hFF);
        `CHK(fields, {8'hFF, 4'hF, 1'h1, 6'h3F, 1'h1, 5'h1F, 4'hF, 1'h1, 1'h1, 1'h1})
        check_image({PT, 8'hFF, ID, 8'hDF, 8'h1F, 16'h0, 8'h3F, 8'h9F, 8'hFF});
        // every code of both select fields, test bits cleared again
        for (int c = 0; c < 32; c++) begin
            host.wrBuf[0] = 8'(c);
            host.wrBuf[1] = 8'(c) & 8'h0F;
            host.write_block(8'h05, 2);
            `CHK(fields[11:1], {5'(c), 4'(c), 2'h0})
        end
        host.read_block(8'h05, 2);
        `CHK({host.rdBuf[0], host.rdBuf[1]}, 16'h1F1F)
        host.wrBuf[0] = 8'h0F;
        host.write_block(8'h05, 1);
        `CHK(fields[11:7], 5'h0F)
        host.probe(8'hA4);
        `CHK(host.ackAll, 1'h0)
        `CHK(fields[11:3], {5'h0F, 4'hF})
        do_reset(1'h0);
        `CHK(fields, {8'hFF, 4'hF, 1'h1, 6'h3F, 1'h0, 5'h0F, 4'h8, 1'h0, 1'h0, 1'h0})
        check_image({PT, 8'h0A, ID, 8'h08, 8'h0F, 16'h0, 8'h3F, 8'h9E, 8'hFF});
        complete_run();
    end
endmodule
`default_nettype wire
